// >>> rtl/tsc_top.sv
// bank of three saturating clear-on-read statistics counters
// assumes event pulses synchronous to mclk_in and an AXI4-Lite master
//
// Operation
// RL1 - count received bridging packets not via engines
// RL2 - skip NWRITE_R, doorbell, maintenance write responses
// RL3 - skip maintenance read responses with tid above 191
// RL4 - count TLPs sent by messaging engine
// RL5 - count TLPs sent by block DMA engine
// RL6 - counters saturate at all ones
// RL7 - reset zero, read returns value, then clears
// RL8 - event during clearing read leaves one
`timescale 1ns/1ps
module tsc_top (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire tsc_pkg::tsc_rx_evt_t rx_evt_in,
	input wire logic msg_tlp_in,
	input wire logic dma_tlp_in,
	input wire logic [tsc_pkg::TSC_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic [2:0] s_axi_awprot_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [tsc_pkg::TSC_DATA_W-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [tsc_pkg::TSC_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic [2:0] s_axi_arprot_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [tsc_pkg::TSC_DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	import tsc_pkg::*;

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);

	// counter storage and next values
	logic [31:0] cnt_reg [TSC_NUM_CNT];
	logic [31:0] cnt_next [TSC_NUM_CNT];
	// per-counter event and clear strobes
	logic [TSC_NUM_CNT-1:0] evt;
	logic [TSC_NUM_CNT-1:0] clr;
	// read and write address hits
	logic [TSC_NUM_CNT-1:0] rd_hit;
	logic [TSC_NUM_CNT-1:0] wr_hit;
	// rx packet filtering
	logic rx_skip;
	logic rx_counted;

	// write channel state
	logic aw_got_reg;
	logic aw_got_next;
	logic w_got_reg;
	logic w_got_next;
	logic aw_hit_reg;
	logic aw_hit_next;
	logic awready_reg;
	logic awready_next;
	logic wready_reg;
	logic wready_next;
	logic bvalid_reg;
	logic bvalid_next;
	logic [1:0] bresp_reg;
	logic [1:0] bresp_next;
	// read channel state
	logic arready_reg;
	logic arready_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [1:0] rresp_reg;
	logic [1:0] rresp_next;
	// handshake strobes
	logic aw_fire;
	logic w_fire;
	logic ar_fire;

	assign aw_fire = s_axi_awvalid_in && awready_reg;
	assign w_fire = s_axi_wvalid_in && wready_reg;
	assign ar_fire = s_axi_arvalid_in && arready_reg;

	// classify the received bridging packet
	always_comb begin
		rx_skip = 1'b0;
		unique case (rx_evt_in.kind)
			// response types never counted
			TSC_RX_NWRITE_R_RESP, TSC_RX_DOORBELL_RESP, TSC_RX_MAINT_WR_RESP: begin
				rx_skip = 1'b1; // RL2
			end
			// out-of-range tid is an error, not counted
			TSC_RX_MAINT_RD_RESP: begin
				rx_skip = (rx_evt_in.tid > TSC_TID_MAX); // RL3
			end
			// ordinary bridged packets and unknown codes count
			default: begin
				rx_skip = 1'b0;
			end
		endcase
		rx_counted = rx_evt_in.valid && !rx_skip; // RL1
	end

	// gather event strobes into one vector
	always_comb begin
		evt = '0;
		evt[TSC_IDX_RX] = rx_counted; // RL1
		evt[TSC_IDX_MSG] = msg_tlp_in; // RL4
		evt[TSC_IDX_DMA] = dma_tlp_in; // RL5
	end

	// address decode, word aligned, low two bits ignored
	generate
		for (genvar d = 0; d < TSC_NUM_CNT; d++) begin : g_dec
			assign rd_hit[d] = (s_axi_araddr_in[17:2] == TSC_OFS_TABLE[d][17:2]);
			assign wr_hit[d] = (s_axi_awaddr_in[17:2] == TSC_OFS_TABLE[d][17:2]);
		end
	endgenerate

	// a read that is taken clears the counter it hits
	assign clr = rd_hit & {TSC_NUM_CNT{ar_fire}}; // RL7

	// one saturating clear-on-read counter per entry
	generate
		for (genvar i = 0; i < TSC_NUM_CNT; i++) begin : g_cnt
			// next value: clear wins over hold, event survives clear
			always_comb begin
				cnt_next[i] = cnt_reg[i];
				if (clr[i]) begin
					// old value goes out on rdata, event kept
					cnt_next[i] = evt[i] ? TSC_CNT_ONE : TSC_CNT_RESET; // RL8
				end else if (evt[i] && (cnt_reg[i] != TSC_CNT_MAX)) begin
					// stop at all ones, never wrap
					cnt_next[i] = cnt_reg[i] + TSC_CNT_ONE; // RL6
				end
			end

			// register the counter
			always_ff @(posedge mclk_in or posedge rst_in) begin
				if (rst_in) begin
					cnt_reg[i] <= TSC_CNT_RESET; // RL7
				end else begin
					cnt_reg[i] <= cnt_next[i];
				end
			end

			// a read handshake on this counter
			sequence s_read_taken;
				ar_fire && rd_hit[i];
			endsequence
			// answer carries the old value
			sequence s_read_answer(logic [31:0] old);
				rvalid_reg && (rdata_reg == old) && (rresp_reg == TSC_RESP_OKAY);
			endsequence

			a_sat_hold: assert property ( // RL6
				(cnt_reg[i] == TSC_CNT_MAX) && !clr[i] |=> (cnt_reg[i] == TSC_CNT_MAX))
				else $error("counter left saturation without read");
			a_read_clear: assert property ( // RL7
				s_read_taken ##0 !evt[i] |=> s_read_answer($past(cnt_reg[i])) ##0 (cnt_reg[i] == TSC_CNT_RESET))
				else $error("read did not return and clear counter");
			a_clear_event_one: assert property ( // RL8
				s_read_taken ##0 evt[i] |=> (cnt_reg[i] == TSC_CNT_ONE) && rvalid_reg)
				else $error("event lost during clearing read");
		end
	endgenerate

	// write channel: writes have no effect, answered after both parts
	always_comb begin
		aw_got_next = aw_got_reg || aw_fire;
		w_got_next = w_got_reg || w_fire;
		aw_hit_next = aw_fire ? (|wr_hit) : aw_hit_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (bvalid_reg && s_axi_bready_in) begin
			// response taken
			bvalid_next = 1'b0;
		end
		if (aw_got_next && w_got_next && !bvalid_reg) begin
			// both halves in, issue the response
			bvalid_next = 1'b1;
			bresp_next = aw_hit_next ? TSC_RESP_OKAY : TSC_RESP_SLVERR;
			aw_got_next = 1'b0;
			w_got_next = 1'b0;
		end
		awready_next = !aw_got_next && !bvalid_next;
		wready_next = !w_got_next && !bvalid_next;
	end

	// register write channel state
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_hit_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= TSC_RESP_OKAY;
		end else begin
			aw_got_reg <= aw_got_next;
			w_got_reg <= w_got_next;
			aw_hit_reg <= aw_hit_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
		end
	end

	// read channel: one read at a time, data one cycle after address
	always_comb begin
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rvalid_reg && s_axi_rready_in) begin
			// data taken
			rvalid_next = 1'b0;
		end
		if (ar_fire) begin
			// capture the old counter value
			rvalid_next = 1'b1;
			rdata_next = TSC_CNT_RESET;
			for (int k = 0; k < TSC_NUM_CNT; k++) begin
				if (rd_hit[k]) begin
					rdata_next = cnt_reg[k]; // RL7
				end
			end
			// unmapped reads return zero and an error
			rresp_next = (|rd_hit) ? TSC_RESP_OKAY : TSC_RESP_SLVERR;
		end
		arready_next = !rvalid_next;
	end

	// register read channel state
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= TSC_CNT_RESET;
			rresp_reg <= TSC_RESP_OKAY;
		end else begin
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready_out = awready_reg;
	assign s_axi_wready_out = wready_reg;
	assign s_axi_bvalid_out = bvalid_reg;
	assign s_axi_bresp_out = bresp_reg;
	assign s_axi_arready_out = arready_reg;
	assign s_axi_rvalid_out = rvalid_reg;
	assign s_axi_rdata_out = rdata_reg;
	assign s_axi_rresp_out = rresp_reg;

	// a counted bridging packet advances the counter by one
	a_rx_count_inc: assert property ( // RL1
		rx_counted && !clr[TSC_IDX_RX] && (cnt_reg[TSC_IDX_RX] != TSC_CNT_MAX)
		|=> cnt_reg[TSC_IDX_RX] == $past(cnt_reg[TSC_IDX_RX]) + TSC_CNT_ONE)
		else $error("bridging packet not counted");

	// excluded response types leave the counter alone
	a_rx_resp_skip: assert property ( // RL2
		rx_evt_in.valid && !clr[TSC_IDX_RX]
		&& (rx_evt_in.kind inside {TSC_RX_NWRITE_R_RESP, TSC_RX_DOORBELL_RESP, TSC_RX_MAINT_WR_RESP})
		|=> $stable(cnt_reg[TSC_IDX_RX]))
		else $error("excluded response was counted");

	// out-of-range maintenance read responses are not counted
	a_rx_tid_skip: assert property ( // RL3
		rx_evt_in.valid && !clr[TSC_IDX_RX] && (rx_evt_in.kind == TSC_RX_MAINT_RD_RESP)
		&& (rx_evt_in.tid > TSC_TID_MAX) |=> $stable(cnt_reg[TSC_IDX_RX]))
		else $error("bad tid response was counted");

	// messaging engine tlp advances its counter
	a_msg_count_inc: assert property ( // RL4
		msg_tlp_in && !clr[TSC_IDX_MSG] && (cnt_reg[TSC_IDX_MSG] != TSC_CNT_MAX)
		|=> cnt_reg[TSC_IDX_MSG] == $past(cnt_reg[TSC_IDX_MSG]) + TSC_CNT_ONE)
		else $error("messaging tlp not counted");

	// block dma engine tlp advances its counter
	a_dma_count_inc: assert property ( // RL5
		dma_tlp_in && !clr[TSC_IDX_DMA] && (cnt_reg[TSC_IDX_DMA] != TSC_CNT_MAX)
		|=> cnt_reg[TSC_IDX_DMA] == $past(cnt_reg[TSC_IDX_DMA]) + TSC_CNT_ONE)
		else $error("dma tlp not counted");

	// without events or reads the dma counter stays put
	a_dma_idle_hold: assert property ( // RL5
		!dma_tlp_in && !clr[TSC_IDX_DMA] |=> $stable(cnt_reg[TSC_IDX_DMA]))
		else $error("dma counter moved without cause");

endmodule : tsc_top

// >>> rtl/tsc_pkg.sv
// package for the traffic statistics counter bank
// assumes one 20 MHz clock and an AXI4-Lite master outside
package tsc_pkg;
	// bus widths
	localparam int unsigned TSC_ADDR_W = 18;
	localparam int unsigned TSC_DATA_W = 32;
	localparam int unsigned TSC_NUM_CNT = 3;
	// byte offsets of the counters
	localparam logic [17:0] TSC_OFS_RX_BRG = 18'h29908;
	localparam logic [17:0] TSC_OFS_MSG_TLP = 18'h2990C;
	localparam logic [17:0] TSC_OFS_DMA_TLP = 18'h29910;
	// offset table, entry i belongs to counter i
	localparam logic [2:0][17:0] TSC_OFS_TABLE = {TSC_OFS_DMA_TLP, TSC_OFS_MSG_TLP, TSC_OFS_RX_BRG};
	// counter indices
	localparam int unsigned TSC_IDX_RX = 0;
	localparam int unsigned TSC_IDX_MSG = 1;
	localparam int unsigned TSC_IDX_DMA = 2;
	// counter values
	localparam logic [31:0] TSC_CNT_RESET = 32'h00000000;
	localparam logic [31:0] TSC_CNT_ONE = 32'h00000001;
	localparam logic [31:0] TSC_CNT_MAX = 32'hFFFFFFFF;
	// highest legal maintenance read transaction id (191)
	localparam logic [7:0] TSC_TID_MAX = 8'hBF;
	// bus response codes
	localparam logic [1:0] TSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] TSC_RESP_SLVERR = 2'h2;
	// class of a packet arriving on the bridging path
	typedef enum logic [2:0] {
		TSC_RX_OTHER = 3'b000,
		TSC_RX_NWRITE_R_RESP = 3'b001,
		TSC_RX_DOORBELL_RESP = 3'b010,
		TSC_RX_MAINT_WR_RESP = 3'b011,
		TSC_RX_MAINT_RD_RESP = 3'b100
	} tsc_rx_kind_t;
	// one received bridging packet, valid for one cycle
	typedef struct packed {
		logic valid;
		tsc_rx_kind_t kind;
		logic [7:0] tid;
	} tsc_rx_evt_t;
endpackage : tsc_pkg

// >>> test/tsc_evt_src.sv
// event source model standing in for the bridging, messaging and dma engines
// assumes the bench calls its tasks and that every pulse lasts one mclk_in cycle
`timescale 1ns/1ps
module tsc_evt_src (
	input wire logic mclk_in,
	output tsc_pkg::tsc_rx_evt_t rx_evt_out,
	output logic msg_tlp_out,
	output logic dma_tlp_out
);
	import tsc_pkg::*;
	// quiet until the bench asks for traffic
	initial begin
		rx_evt_out = '0;
		msg_tlp_out = 1'b0;
		dma_tlp_out = 1'b0;
	end
	// one cycle of events, launched just after a rising edge
	task ev(input logic r, input tsc_rx_kind_t k, input logic [7:0] t, input logic m, input logic d);
		@(posedge mclk_in);
		rx_evt_out <= '{valid: r, kind: k, tid: t};
		msg_tlp_out <= m;
		dma_tlp_out <= d;
	endtask : ev
	// one cycle with every strobe low
	task idle;
		ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b0, 1'b0);
	endtask : idle
endmodule : tsc_evt_src

// >>> test/tb.sv
// self-checking bench for the statistics counter bank
// assumes tsc_pkg, tsc_top and the event source model are compiled first
`timescale 1ns/1ps
module tb;
	import tsc_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [17:0] awaddr = 18'h00000;
	logic [17:0] araddr = 18'h00000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	tsc_rx_evt_t rx_evt;
	logic msg_tlp, dma_tlp;
	int mismatches = 0;
	int n_compared = 0;
	// 20 MHz clock
	initial forever #25 mclk_in = ~mclk_in;
	tsc_evt_src src (.mclk_in(mclk_in), .rx_evt_out(rx_evt), .msg_tlp_out(msg_tlp), .dma_tlp_out(dma_tlp));
	tsc_top dut (.mclk_in(mclk_in), .rst_in(rst_in), .rx_evt_in(rx_evt), .msg_tlp_in(msg_tlp),
		.dma_tlp_in(dma_tlp), .s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(32'hA5A5A5A5), .s_axi_wstrb_in(4'hF),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready));
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// one read, held until taken, then checked
	task rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge mclk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge mclk_in);
		rready <= 1'b0;
		// address channel refused while read data stands
		chk({31'h0, arready}, 32'h00000000);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask : rd
	// one write, address and data offered together
	task wr(input logic [17:0] a, input logic [1:0] er);
		@(posedge mclk_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge mclk_in);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
		bready <= 1'b1;
		do @(posedge mclk_in); while (bvalid !== 1'b1);
		bready <= 1'b0;
		// both write channels refused while the response stands
		chk({30'h0, awready, wready}, 32'h00000000);
		chk({30'h0, bresp}, {30'h0, er});
	endtask : wr
	// every counter reads zero after reset
	task t_reset;
		for (int i = 0; i < 3; i++) rd(TSC_OFS_TABLE[i], TSC_CNT_RESET, TSC_RESP_OKAY);
	endtask : t_reset
	// counted and excluded packet classes, back to back
	task t_filter;
		src.ev(1'b1, TSC_RX_OTHER, 8'h00, 1'b1, 1'b1);
		src.ev(1'b1, TSC_RX_MAINT_RD_RESP, TSC_TID_MAX, 1'b1, 1'b0);
		src.ev(1'b1, tsc_rx_kind_t'(3'h5), 8'h00, 1'b1, 1'b0);
		src.ev(1'b1, TSC_RX_NWRITE_R_RESP, 8'h00, 1'b0, 1'b1);
		src.ev(1'b1, TSC_RX_DOORBELL_RESP, 8'h00, 1'b0, 1'b0);
		src.ev(1'b1, TSC_RX_MAINT_WR_RESP, 8'h00, 1'b0, 1'b0);
		src.ev(1'b1, TSC_RX_MAINT_RD_RESP, 8'hC0, 1'b0, 1'b0);
		src.idle;
		rd(TSC_OFS_RX_BRG, 32'h00000003, TSC_RESP_OKAY);
		rd(TSC_OFS_MSG_TLP, 32'h00000003, TSC_RESP_OKAY);
		rd(TSC_OFS_DMA_TLP, 32'h00000002, TSC_RESP_OKAY);
		rd(TSC_OFS_RX_BRG, TSC_CNT_RESET, TSC_RESP_OKAY);
	endtask : t_filter
	// event lands on the clearing read edge
	task t_race;
		src.ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b1, 1'b0);
		src.ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b1, 1'b0);
		src.idle;
		fork
			rd(TSC_OFS_MSG_TLP, 32'h00000002, TSC_RESP_OKAY);
			begin
				src.ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b1, 1'b0);
				src.idle;
			end
		join
		rd(TSC_OFS_MSG_TLP, TSC_CNT_ONE, TSC_RESP_OKAY);
	endtask : t_race
	// writes leave counters alone, unmapped places refuse
	task t_bus;
		src.ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b0, 1'b1);
		src.idle;
		wr(TSC_OFS_DMA_TLP, TSC_RESP_OKAY);
		rd(TSC_OFS_DMA_TLP, TSC_CNT_ONE, TSC_RESP_OKAY);
		wr(18'h00000, TSC_RESP_SLVERR);
		rd(18'h29914, TSC_CNT_RESET, TSC_RESP_SLVERR);
	endtask : t_bus
	// mid-run reset clears a counter that holds a count
	task t_rst;
		src.ev(1'b0, TSC_RX_OTHER, 8'h00, 1'b1, 1'b0);
		src.idle;
		@(posedge mclk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		// read address refused while reset holds
		chk({31'h0, arready}, 32'h00000000);
		rd(TSC_OFS_MSG_TLP, TSC_CNT_RESET, TSC_RESP_OKAY);
	endtask : t_rst
	// verdict and end of run
	task end_sim;
		$display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// main sequence, reset held three cycles
	initial begin
		repeat (3) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_reset;
		t_filter;
		t_race;
		t_bus;
		t_rst;
		end_sim;
	end
	// hang guard, far beyond the fewer than a hundred cycles needed
	initial begin
		#250000;
		mismatches++;
		end_sim;
	end
endmodule : tb
